// ---- tic_core_model.sv ----
// Behavioural model of the core sequencer that feeds the interrupt block
module tic_core_model (
	input wire logic mclk,
	input wire logic rst,
	input wire logic ret_req,
	input wire logic en_wr_req,
	output logic mcycle,
	output logic instr_end,
	output logic instr_is_return,
	output logic instr_wr_en_prio
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] phase_q;
	// ========================================
	// Instruction phase counter
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			phase_q <= 2'h0;
		end else begin
			phase_q <= phase_q + 2'h1;
		end
	end
	// ========================================
	// Sample pulse, then an instruction end two cycles later
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			mcycle <= 1'b0;
			instr_end <= 1'b0;
			instr_is_return <= 1'b0;
			instr_wr_en_prio <= 1'b0;
		end else begin
			mcycle <= (phase_q == 2'h0);
			instr_end <= (phase_q == 2'h2);
			instr_is_return <= (phase_q == 2'h2) && ret_req;
			// Enable or priority write instruction on request
			instr_wr_en_prio <= (phase_q == 2'h2) && en_wr_req;
		end
	end
endmodule // tic_core_model

// ---- tic_ctrl.sv ----
// Timer units, interrupt flags, enables and vectored interrupt acceptance
// Notes on behaviour
// RL1: Gate bit needs run bit and input
// RL2: Gated counting on falling input edges
// RL3: Select bit picks events or machine cycles
// RL4: Two-bit mode field per unit
// RL5: Mode 0 13-bit, mode 1 16-bit
// RL6: Mode 2 reload, mode 3 split/stop
// RL7: Timer advances every 12 clocks
// RL8: Unit 1 overflow flag, cleared on service
// RL9: Unit 0 overflow flag, cleared on service
// RL10: Run bits start and halt units
// RL11: Ext 1 flag set on fall, service clears
// RL12: Ext 0 flag set on fall, service clears
// RL13: Type bit picks edge or level trigger
// RL14: Type 0 level, type 1 falling edge
// RL15: Eleven sources over four levels
// RL16: Each source has own enable bit
// RL17: Acceptance jumps to per-source vector
// RL18: Only strictly higher level preempts service
// RL19: Return ends service, core resumes
// RL20: Flags set regardless of enables
// RL21: Flags sampled each machine cycle, polled
// RL22: Accepted request forces long call next
// RL23: Withhold while equal/higher level served
// RL24: Withhold during return or enable writes
// RL25: Global enable zero blocks everything
// RL26: Primary enable bit assignment
// RL27: Reset clears enables, runs, flags
// RL28: Ties resolved in fixed source order
module tic_ctrl #(
	parameter int NUM_PERIPH = tic_pkg::NUM_PERIPH
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata_q,
	input wire logic ext0_input_pin,
	input wire logic ext1_input_pin,
	input wire logic [1:0] count_in,
	input wire logic serial0_req,
	input wire logic [NUM_PERIPH-1:0] periph_req,
	input wire logic [NUM_PERIPH-1:0] periph_en,
	input wire logic [2*tic_pkg::NUM_SRC-1:0] src_prio,
	input wire logic mcycle,
	input wire logic instr_end,
	input wire logic instr_is_return,
	input wire logic instr_wr_en_prio,
	output logic irq_call_q,
	output logic [15:0] irq_vector_q,
	output logic [tic_pkg::NUM_SRC-1:0] src_ack_q,
	output logic [tic_pkg::NUM_LEVEL-1:0] in_service_q
);
	localparam int NS = tic_pkg::NUM_SRC;
	logic [7:0] run_flag_q;
	logic [7:0] mode_cfg_q;
	logic [7:0] irq_en_q;
	logic [3:0] tick_cnt_q;
	logic tick;
	logic [1:0] cnt_prev_q;
	logic ext0_prev_q;
	logic ext1_prev_q;
	logic [1:0] cnt_fall;
	logic ext0_fall;
	logic ext1_fall;
	logic [1:0] gate_pin;
	logic [1:0] unit_en;
	logic [1:0] unit_src;
	logic u0_inc_lo;
	logic u0_inc_hi;
	logic u1_inc_lo;
	tic_pkg::tic_mode_e u0_mode;
	tic_pkg::tic_mode_e u1_mode;
	logic [7:0] u0_low;
	logic [7:0] u0_high;
	logic [7:0] u1_low;
	logic [7:0] u1_high;
	logic u0_ovf;
	logic u0_ovf_hi;
	logic u1_ovf;
	logic u1_ovf_dummy;
	logic wr_run_flag;
	logic wr_en_reg;
	logic [NS-1:0] req_raw;
	logic [NS-1:0] req_en;
	logic [NS-1:0] poll_q;
	logic [3:0] best_idx;
	logic [1:0] best_lvl;
	logic best_any;
	logic [1:0] cur_lvl;
	logic any_isr;
	logic grant;
	logic [NS-1:0] grant_hot;
	logic ret_done;

	assign wr_run_flag = sfr_wr && (sfr_addr == tic_pkg::ADDR_RUN_FLAG);
	assign wr_en_reg = sfr_wr && (sfr_addr == tic_pkg::ADDR_IRQ_EN);
	assign ret_done = instr_end && instr_is_return;

	// ========================================
	// Configuration registers
	// RL27: reset clears all
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			mode_cfg_q <= tic_pkg::RST_BYTE;
			irq_en_q <= tic_pkg::RST_BYTE;
		end else begin
			if (sfr_wr && sfr_addr == tic_pkg::ADDR_MODE_CFG) begin
				mode_cfg_q <= sfr_wdata;
			end
			// RL16: per-source enables
			if (wr_en_reg) begin
				irq_en_q <= sfr_wdata & tic_pkg::IRQ_EN_USED;
			end
		end
	end

	// ========================================
	// Machine cycle prescaler
	// RL7: one tick per 12 clocks
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			tick_cnt_q <= 4'h0;
		end else begin
			tick_cnt_q <= tick ? 4'h0 : tick_cnt_q + 4'h1;
		end
	end
	assign tick = (tick_cnt_q == tic_pkg::TICK_LAST);

	// Previous input levels for falling edge detection
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cnt_prev_q <= 2'h3;
			ext0_prev_q <= 1'b1;
			ext1_prev_q <= 1'b1;
		end else begin
			cnt_prev_q <= count_in;
			ext0_prev_q <= ext0_input_pin;
			ext1_prev_q <= ext1_input_pin;
		end
	end
	assign ext0_fall = ext0_prev_q && !ext0_input_pin;
	assign ext1_fall = ext1_prev_q && !ext1_input_pin;
	assign gate_pin = {ext1_input_pin, ext0_input_pin};

	// ========================================
	// Count enables per unit
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_unit
			localparam int GB = gi ? tic_pkg::BIT_U1_GATE : tic_pkg::BIT_U0_GATE;
			localparam int CB = gi ? tic_pkg::BIT_U1_CT : tic_pkg::BIT_U0_CT;
			localparam int RB = gi ? tic_pkg::BIT_U1_RUN : tic_pkg::BIT_U0_RUN;
			assign cnt_fall[gi] = cnt_prev_q[gi] && !count_in[gi];
			// RL10: run bit, RL1: gate needs input
			assign unit_en[gi] = run_flag_q[RB]
				&& (!mode_cfg_q[GB] || gate_pin[gi]);
			// RL3: events or cycles, RL2: gated edges
			assign unit_src[gi] = (mode_cfg_q[CB] || mode_cfg_q[GB])
				? cnt_fall[gi] : tick;
		end
	endgenerate

	// RL4: mode fields per unit
	assign u0_mode = tic_pkg::tic_mode_e'(mode_cfg_q[tic_pkg::BIT_U0_MODE +: 2]);
	assign u1_mode = tic_pkg::tic_mode_e'(mode_cfg_q[tic_pkg::BIT_U1_MODE +: 2]);
	assign u0_inc_lo = unit_en[0] && unit_src[0];
	// RL6: split high byte runs on unit 1 run bit
	assign u0_inc_hi = run_flag_q[tic_pkg::BIT_U1_RUN] && tick;
	// RL6: unit 1 stops in split mode
	assign u1_inc_lo = (u1_mode != tic_pkg::MODE_SPLIT)
		&& unit_en[1] && unit_src[1];

	tic_timer_unit u_unit0 (
		.mclk(mclk),
		.rst(rst),
		.mode(u0_mode),
		.inc_lo(u0_inc_lo),
		.inc_hi(u0_inc_hi),
		.wr_lo(sfr_wr && sfr_addr == tic_pkg::ADDR_U0_LOW),
		.wr_hi(sfr_wr && sfr_addr == tic_pkg::ADDR_U0_HIGH),
		.wdata(sfr_wdata),
		.low_q(u0_low),
		.high_q(u0_high),
		.ovf_q(u0_ovf),
		.ovf_hi_q(u0_ovf_hi)
	);

	tic_timer_unit u_unit1 (
		.mclk(mclk),
		.rst(rst),
		.mode(u1_mode),
		.inc_lo(u1_inc_lo),
		.inc_hi(1'b0),
		.wr_lo(sfr_wr && sfr_addr == tic_pkg::ADDR_U1_LOW),
		.wr_hi(sfr_wr && sfr_addr == tic_pkg::ADDR_U1_HIGH),
		.wdata(sfr_wdata),
		.low_q(u1_low),
		.high_q(u1_high),
		.ovf_q(u1_ovf),
		.ovf_hi_q(u1_ovf_dummy)
	);

	// ========================================
	// Run bits, trigger types and request flags
	// RL20: flags set independent of enables; set wins over clears
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			run_flag_q <= tic_pkg::RST_BYTE;
		end else begin
			if (wr_run_flag) begin
				run_flag_q[tic_pkg::BIT_U1_RUN] <= sfr_wdata[tic_pkg::BIT_U1_RUN];
				run_flag_q[tic_pkg::BIT_U0_RUN] <= sfr_wdata[tic_pkg::BIT_U0_RUN];
				run_flag_q[tic_pkg::BIT_EXT1_TYPE] <=
					sfr_wdata[tic_pkg::BIT_EXT1_TYPE];
				run_flag_q[tic_pkg::BIT_EXT0_TYPE] <=
					sfr_wdata[tic_pkg::BIT_EXT0_TYPE];
			end
			// RL8: unit 1 overflow flag
			run_flag_q[tic_pkg::BIT_U1_OVF] <= u1_ovf || u0_ovf_hi
				|| (run_flag_q[tic_pkg::BIT_U1_OVF]
				&& !(wr_run_flag && !sfr_wdata[tic_pkg::BIT_U1_OVF])
				&& !grant_hot[tic_pkg::SRC_U1]);
			// RL9: unit 0 overflow flag
			run_flag_q[tic_pkg::BIT_U0_OVF] <= u0_ovf
				|| (run_flag_q[tic_pkg::BIT_U0_OVF]
				&& !(wr_run_flag && !sfr_wdata[tic_pkg::BIT_U0_OVF])
				&& !grant_hot[tic_pkg::SRC_U0]);
			// RL11: ext 1 flag, RL13/RL14: edge or level
			run_flag_q[tic_pkg::BIT_EXT1_REQ] <=
				(run_flag_q[tic_pkg::BIT_EXT1_TYPE] ? ext1_fall : !ext1_input_pin)
				|| (run_flag_q[tic_pkg::BIT_EXT1_REQ]
				&& !(wr_run_flag && !sfr_wdata[tic_pkg::BIT_EXT1_REQ])
				&& !grant_hot[tic_pkg::SRC_EXT1]);
			// RL12: ext 0 flag, RL13/RL14: edge or level
			run_flag_q[tic_pkg::BIT_EXT0_REQ] <=
				(run_flag_q[tic_pkg::BIT_EXT0_TYPE] ? ext0_fall : !ext0_input_pin)
				|| (run_flag_q[tic_pkg::BIT_EXT0_REQ]
				&& !(wr_run_flag && !sfr_wdata[tic_pkg::BIT_EXT0_REQ])
				&& !grant_hot[tic_pkg::SRC_EXT0]);
		end
	end

	// ========================================
	// Request gathering and polling
	// RL15: eleven sources, RL26: primary enable bits
	assign req_raw = {periph_req, serial0_req,
		run_flag_q[tic_pkg::BIT_U1_OVF], run_flag_q[tic_pkg::BIT_EXT1_REQ],
		run_flag_q[tic_pkg::BIT_U0_OVF], run_flag_q[tic_pkg::BIT_EXT0_REQ]};
	// RL25: global enable gates all
	assign req_en = irq_en_q[tic_pkg::BIT_GLOBAL_EN]
		? {periph_en, irq_en_q[4:0]} : '0;

	// RL21: sample once per machine cycle
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			poll_q <= '0;
		end else if (mcycle) begin
			poll_q <= req_raw & req_en & ~grant_hot;
		end else begin
			poll_q <= poll_q & ~grant_hot;
		end
	end

	// RL28: fixed order, highest level first
	always_comb begin
		best_idx = 4'h0;
		best_lvl = 2'h0;
		best_any = 1'b0;
		for (int i = 0; i < NS; i++) begin
			if (poll_q[i] && (!best_any || src_prio[2*i +: 2] > best_lvl)) begin
				best_idx = 4'(i);
				best_lvl = src_prio[2*i +: 2];
				best_any = 1'b1;
			end
		end
	end

	// Highest level now in service
	always_comb begin
		cur_lvl = 2'h0;
		for (int l = 0; l < tic_pkg::NUM_LEVEL; l++) begin
			if (in_service_q[l]) begin
				cur_lvl = 2'(l);
			end
		end
	end
	assign any_isr = |in_service_q;

	// RL18/RL23: higher level only; RL24: blockers; RL25: global enable
	assign grant = best_any && instr_end && !instr_is_return
		&& !instr_wr_en_prio && !wr_en_reg
		&& irq_en_q[tic_pkg::BIT_GLOBAL_EN]
		&& (!any_isr || best_lvl > cur_lvl);
	assign grant_hot = grant ? NS'(1) << best_idx : '0;

	// ========================================
	// Acceptance toward the core
	// RL22: forced long call; RL17: per-source vector
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			irq_call_q <= 1'b0;
			irq_vector_q <= 16'h0000;
			src_ack_q <= '0;
		end else begin
			irq_call_q <= grant;
			src_ack_q <= grant_hot;
			if (grant) begin
				irq_vector_q <= tic_pkg::VEC_BASE
					+ (16'(best_idx) << tic_pkg::VEC_SHIFT);
			end
		end
	end

	// RL19: return closes highest level in service
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			in_service_q <= '0;
		end else if (grant) begin
			in_service_q[best_lvl] <= 1'b1;
		end else if (ret_done && any_isr) begin
			in_service_q[cur_lvl] <= 1'b0;
		end
	end

	// ========================================
	// Register read port, unmapped reads give zero
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			sfr_rdata_q <= 8'h00;
		end else if (sfr_rd) begin
			unique case (sfr_addr)
			tic_pkg::ADDR_RUN_FLAG: sfr_rdata_q <= run_flag_q;
			tic_pkg::ADDR_MODE_CFG: sfr_rdata_q <= mode_cfg_q;
			tic_pkg::ADDR_IRQ_EN: sfr_rdata_q <= irq_en_q;
			tic_pkg::ADDR_U0_LOW: sfr_rdata_q <= u0_low;
			tic_pkg::ADDR_U0_HIGH: sfr_rdata_q <= u0_high;
			tic_pkg::ADDR_U1_LOW: sfr_rdata_q <= u1_low;
			tic_pkg::ADDR_U1_HIGH: sfr_rdata_q <= u1_high;
			default: sfr_rdata_q <= 8'h00;
			endcase
		end
	end

	// ========================================
	// Checks
	AST_PRESCALE: assert property (@(posedge mclk) disable iff (rst) // RL7
		tick |=> !tick [*8] ##1 !tick [*3] ##1 tick)
		else $error("Prescaler period is not 12");
	AST_HALTED: assert property (@(posedge mclk) disable iff (rst) // RL10
		(!run_flag_q[tic_pkg::BIT_U0_RUN] && !sfr_wr) |=> $stable(u0_low))
		else $error("Unit 0 low byte moved while halted");
	AST_TF0_SET: assert property (@(posedge mclk) disable iff (rst) // RL9
		u0_ovf |=> run_flag_q[tic_pkg::BIT_U0_OVF])
		else $error("Overflow did not set unit 0 flag");
	AST_TF1_ACK: assert property (@(posedge mclk) disable iff (rst) // RL8
		(grant_hot[tic_pkg::SRC_U1] && !u1_ovf && !u0_ovf_hi)
		|=> !run_flag_q[tic_pkg::BIT_U1_OVF])
		else $error("Service did not clear unit 1 flag");
	AST_EDGE0: assert property (@(posedge mclk) disable iff (rst) // RL12
		(ext0_fall && run_flag_q[tic_pkg::BIT_EXT0_TYPE])
		|=> run_flag_q[tic_pkg::BIT_EXT0_REQ])
		else $error("Falling edge missed on ext 0");
	AST_GLOBAL: assert property (@(posedge mclk) disable iff (rst) // RL25
		irq_call_q |-> $past(irq_en_q[tic_pkg::BIT_GLOBAL_EN]))
		else $error("Call with global enable off");
	AST_NO_RETURN_CALL: assert property (@(posedge mclk) disable iff (rst) // RL24
		ret_done |=> !irq_call_q)
		else $error("Call accepted during return");
	AST_PREEMPT: assert property (@(posedge mclk) disable iff (rst) // RL18
		(irq_call_q && $past(any_isr)) |-> $past(best_lvl > cur_lvl))
		else $error("Preemption without higher level");
	AST_VECTOR: assert property (@(posedge mclk) disable iff (rst) // RL17
		grant |=> irq_call_q && irq_vector_q == tic_pkg::VEC_BASE
		+ (16'($past(best_idx)) << tic_pkg::VEC_SHIFT))
		else $error("Vector does not match source");
endmodule // tic_ctrl

// ---- tic_ctrl_tb_top.sv ----
// Self-checking bench for the timer and interrupt control block
module tic_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] sfr_addr = 8'h00;
	logic sfr_wr = 1'b0;
	logic sfr_rd = 1'b0;
	logic [7:0] sfr_wdata = 8'h00;
	logic [7:0] sfr_rdata_q;
	logic pin0 = 1'b1;
	logic pin1 = 1'b1;
	logic [1:0] count_in = 2'h3;
	logic ret_req = 1'b0;
	logic en_wr = 1'b0;
	logic [21:0] prio = 22'h000000;
	logic mcycle, instr_end, instr_is_return, instr_wr_en_prio;
	logic irq_call_q;
	logic [15:0] irq_vector_q;
	logic [10:0] src_ack_q;
	logic [3:0] in_service_q;
	int error_cnt = 0;
	int checked = 0;
	bit seen;
	always #12.5 mclk = ~mclk;
	// ========================================
	// Block under test and core model
	tic_ctrl uut (.mclk(mclk), .rst(rst), .sfr_addr(sfr_addr),
		.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
		.sfr_rdata_q(sfr_rdata_q), .ext0_input_pin(pin0),
		.ext1_input_pin(pin1), .count_in(count_in), .serial0_req(1'b0),
		.periph_req(6'h00), .periph_en(6'h00), .src_prio(prio),
		.mcycle(mcycle), .instr_end(instr_end),
		.instr_is_return(instr_is_return),
		.instr_wr_en_prio(instr_wr_en_prio),
		.irq_call_q(irq_call_q), .irq_vector_q(irq_vector_q),
		.src_ack_q(src_ack_q), .in_service_q(in_service_q));
	tic_core_model core (.mclk(mclk), .rst(rst), .ret_req(ret_req),
		.en_wr_req(en_wr), .mcycle(mcycle), .instr_end(instr_end),
		.instr_is_return(instr_is_return),
		.instr_wr_en_prio(instr_wr_en_prio));
	// ========================================
	// Bus cycles and comparison
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		@(posedge mclk);
		sfr_wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge mclk);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(posedge mclk);
		sfr_rd <= 1'b0;
		#1;
		chk({8'h00, sfr_rdata_q}, {8'h00, exp});
	endtask
	task automatic wait_call(input int n);
		seen = 1'b0;
		for (int i = 0; i < n && !seen; i++) begin
			@(posedge mclk);
			#1;
			seen = (irq_call_q === 1'b1);
		end
	endtask
	task automatic call_chk(input logic [15:0] vec, input logic [10:0] ack,
		input logic [3:0] isr);
		wait_call(60);
		chk({15'h0000, seen}, 16'h0001);
		chk(irq_vector_q, vec);
		chk({5'h00, src_ack_q}, {5'h00, ack});
		chk({12'h000, in_service_q}, {12'h000, isr});
	endtask
	// Holds the return request until the core has issued one return
	task automatic do_return(input logic [3:0] isr);
		@(posedge mclk);
		ret_req <= 1'b1;
		do begin
			@(posedge mclk);
		end while (instr_is_return !== 1'b1);
		ret_req <= 1'b0;
		#1;
		chk({12'h000, in_service_q}, {12'h000, isr});
	endtask
	// ========================================
	// Scenarios
	task automatic t_reset();
		rd_chk(tic_pkg::ADDR_RUN_FLAG, 8'h00);
		rd_chk(tic_pkg::ADDR_MODE_CFG, 8'h00);
		rd_chk(tic_pkg::ADDR_IRQ_EN, 8'h00);
		rd_chk(8'h90, 8'h00);
	endtask
	task automatic t_mask();
		wr(tic_pkg::ADDR_IRQ_EN, 8'hFF);
		rd_chk(tic_pkg::ADDR_IRQ_EN, 8'h9F);
		wr(tic_pkg::ADDR_IRQ_EN, 8'h01);
		wr(tic_pkg::ADDR_RUN_FLAG, 8'h01);
		@(posedge mclk);
		pin0 <= 1'b0;
		wait_call(30);
		chk({15'h0000, seen}, 16'h0000);
		@(posedge mclk);
		pin0 <= 1'b1;
		rd_chk(tic_pkg::ADDR_RUN_FLAG, 8'h03);
		wr(tic_pkg::ADDR_RUN_FLAG, 8'h01);
		rd_chk(tic_pkg::ADDR_RUN_FLAG, 8'h01);
	endtask
	task automatic t_edge_tie();
		wr(tic_pkg::ADDR_RUN_FLAG, 8'h05);
		wr(tic_pkg::ADDR_IRQ_EN, 8'h85);
		@(posedge mclk);
		pin0 <= 1'b0;
		pin1 <= 1'b0;
		call_chk(16'h0003, 11'h001, 4'h1);
		@(posedge mclk);
		pin0 <= 1'b1;
		pin1 <= 1'b1;
		wait_call(24);
		chk({15'h0000, seen}, 16'h0000);
		do_return(4'h0);
		call_chk(16'h0013, 11'h004, 4'h1);
		do_return(4'h0);
		rd_chk(tic_pkg::ADDR_RUN_FLAG, 8'h05);
	endtask
	// Ext 1 at level 1 interrupts the ext 0 service at level 0
	task automatic t_preempt();
		wr(tic_pkg::ADDR_RUN_FLAG, 8'h05);
		prio <= 22'h000010;
		@(posedge mclk);
		pin0 <= 1'b0;
		call_chk(16'h0003, 11'h001, 4'h1);
		@(posedge mclk);
		pin0 <= 1'b1;
		pin1 <= 1'b0;
		call_chk(16'h0013, 11'h004, 4'h3);
		@(posedge mclk);
		pin1 <= 1'b1;
		do_return(4'h1);
		do_return(4'h0);
	endtask
	task automatic t_timer_irq();
		wr(tic_pkg::ADDR_IRQ_EN, 8'h82);
		wr(tic_pkg::ADDR_MODE_CFG, 8'h01);
		wr(tic_pkg::ADDR_U0_HIGH, 8'hFF);
		wr(tic_pkg::ADDR_U0_LOW, 8'hFF);
		en_wr <= 1'b1;
		wr(tic_pkg::ADDR_RUN_FLAG, 8'h15);
		wait_call(30);
		chk({15'h0000, seen}, 16'h0000);
		@(posedge mclk);
		en_wr <= 1'b0;
		call_chk(16'h000B, 11'h002, 4'h1);
		rd_chk(tic_pkg::ADDR_RUN_FLAG, 8'h15);
		wr(tic_pkg::ADDR_RUN_FLAG, 8'h05);
		do_return(4'h0);
	endtask
	task automatic t_timed_count();
		wr(tic_pkg::ADDR_U0_LOW, 8'h00);
		wr(tic_pkg::ADDR_U0_HIGH, 8'h00);
		wr(tic_pkg::ADDR_RUN_FLAG, 8'h15);
		repeat (58) @(posedge mclk);
		wr(tic_pkg::ADDR_RUN_FLAG, 8'h05);
		repeat (30) @(posedge mclk);
		rd_chk(tic_pkg::ADDR_U0_LOW, 8'h05);
		rd_chk(tic_pkg::ADDR_U0_HIGH, 8'h00);
	endtask
	task automatic pulses(input int n);
		repeat (n) begin
			count_in[0] <= 1'b0;
			repeat (12) @(posedge mclk);
			count_in[0] <= 1'b1;
			repeat (12) @(posedge mclk);
		end
	endtask
	task automatic t_gated_count();
		wr(tic_pkg::ADDR_MODE_CFG, 8'h0D);
		wr(tic_pkg::ADDR_U0_LOW, 8'h00);
		wr(tic_pkg::ADDR_RUN_FLAG, 8'h15);
		pulses(3);
		rd_chk(tic_pkg::ADDR_U0_LOW, 8'h03);
		@(posedge mclk);
		pin0 <= 1'b0;
		pulses(2);
		rd_chk(tic_pkg::ADDR_U0_LOW, 8'h03);
		@(posedge mclk);
		pin0 <= 1'b1;
		wr(tic_pkg::ADDR_RUN_FLAG, 8'h05);
		pulses(2);
		rd_chk(tic_pkg::ADDR_U0_LOW, 8'h03);
	endtask
	// Reload, 13-bit and split modes, each run for exactly five ticks
	task automatic t_modes();
		wr(tic_pkg::ADDR_IRQ_EN, 8'h00);
		wr(tic_pkg::ADDR_MODE_CFG, 8'h02);
		wr(tic_pkg::ADDR_U0_HIGH, 8'hF0);
		wr(tic_pkg::ADDR_U0_LOW, 8'hFE);
		wr(tic_pkg::ADDR_RUN_FLAG, 8'h15);
		repeat (58) @(posedge mclk);
		wr(tic_pkg::ADDR_RUN_FLAG, 8'h25);
		rd_chk(tic_pkg::ADDR_U0_LOW, 8'hF3);
		rd_chk(tic_pkg::ADDR_RUN_FLAG, 8'h25);
		wr(tic_pkg::ADDR_MODE_CFG, 8'h00);
		wr(tic_pkg::ADDR_U1_HIGH, 8'hFF);
		wr(tic_pkg::ADDR_U1_LOW, 8'h1F);
		wr(tic_pkg::ADDR_RUN_FLAG, 8'h45);
		repeat (58) @(posedge mclk);
		wr(tic_pkg::ADDR_RUN_FLAG, 8'h85);
		rd_chk(tic_pkg::ADDR_U1_LOW, 8'h04);
		rd_chk(tic_pkg::ADDR_U1_HIGH, 8'h00);
		rd_chk(tic_pkg::ADDR_RUN_FLAG, 8'h85);
		wr(tic_pkg::ADDR_MODE_CFG, 8'h33);
		wr(tic_pkg::ADDR_U0_LOW, 8'h00);
		wr(tic_pkg::ADDR_U0_HIGH, 8'hFE);
		wr(tic_pkg::ADDR_RUN_FLAG, 8'h55);
		repeat (58) @(posedge mclk);
		wr(tic_pkg::ADDR_RUN_FLAG, 8'h85);
		rd_chk(tic_pkg::ADDR_U0_LOW, 8'h05);
		rd_chk(tic_pkg::ADDR_U0_HIGH, 8'h03);
		rd_chk(tic_pkg::ADDR_U1_LOW, 8'h04);
		rd_chk(tic_pkg::ADDR_RUN_FLAG, 8'h85);
	endtask
	// ========================================
	// Verdict and end of run
	task automatic complete_run();
		if (error_cnt == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge mclk);
		error_cnt++;
		complete_run();
	end
	// Main sequence
	initial begin
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		t_reset();
		t_mask();
		t_edge_tie();
		t_preempt();
		t_timer_irq();
		t_timed_count();
		t_gated_count();
		t_modes();
		complete_run();
	end
endmodule // tic_ctrl_tb_top

// ---- tic_pkg.sv ----
// Constants and types shared by the timer and interrupt control block
package tic_pkg;
	// ========================================
	// Register addresses on the special register port
	localparam logic [7:0] ADDR_RUN_FLAG = 8'h88;
	localparam logic [7:0] ADDR_MODE_CFG = 8'h89;
	localparam logic [7:0] ADDR_IRQ_EN = 8'hA8;
	localparam logic [7:0] ADDR_U0_LOW = 8'h8A;
	localparam logic [7:0] ADDR_U1_LOW = 8'h8B;
	localparam logic [7:0] ADDR_U0_HIGH = 8'h8C;
	localparam logic [7:0] ADDR_U1_HIGH = 8'h8D;
	// ========================================
	// Field positions in the run and flag register
	localparam int BIT_U1_OVF = 7;
	localparam int BIT_U1_RUN = 6;
	localparam int BIT_U0_OVF = 5;
	localparam int BIT_U0_RUN = 4;
	localparam int BIT_EXT1_REQ = 3;
	localparam int BIT_EXT1_TYPE = 2;
	localparam int BIT_EXT0_REQ = 1;
	localparam int BIT_EXT0_TYPE = 0;
	// Field positions in the mode register
	localparam int BIT_U1_GATE = 7;
	localparam int BIT_U1_CT = 6;
	localparam int BIT_U1_MODE = 4;
	localparam int BIT_U0_GATE = 3;
	localparam int BIT_U0_CT = 2;
	localparam int BIT_U0_MODE = 0;
	// Field positions in the primary enable register
	localparam int BIT_GLOBAL_EN = 7;
	localparam logic [7:0] IRQ_EN_USED = 8'h9F;
	// ========================================
	// Values after reset
	localparam logic [7:0] RST_BYTE = 8'h00;
	// ========================================
	// Counts and sizes
	localparam int TICK_DIV = 12;
	localparam logic [3:0] TICK_LAST = 4'(TICK_DIV - 1);
	localparam int NUM_SRC = 11;
	localparam int NUM_LEVEL = 4;
	localparam int NUM_PERIPH = 6;
	// Source order, lowest index wins a tie
	localparam logic [3:0] SRC_EXT0 = 4'h0;
	localparam logic [3:0] SRC_U0 = 4'h1;
	localparam logic [3:0] SRC_EXT1 = 4'h2;
	localparam logic [3:0] SRC_U1 = 4'h3;
	// Vector table: base plus a fixed stride per source
	localparam logic [15:0] VEC_BASE = 16'h0003;
	localparam int VEC_SHIFT = 3;
	// ========================================
	// Operating modes of a counter unit
	typedef enum logic [1:0] {
		MODE_13BIT,
		MODE_16BIT,
		MODE_RELOAD8,
		MODE_SPLIT
	} tic_mode_e;
endpackage

// ---- tic_timer_unit.sv ----
// One counter unit: low and high byte with four operating modes
module tic_timer_unit (
	input wire logic mclk,
	input wire logic rst,
	input wire tic_pkg::tic_mode_e mode,
	input wire logic inc_lo,
	input wire logic inc_hi,
	input wire logic wr_lo,
	input wire logic wr_hi,
	input wire logic [7:0] wdata,
	output logic [7:0] low_q,
	output logic [7:0] high_q,
	output logic ovf_q,
	output logic ovf_hi_q
);
	// ========================================
	// Counting per mode
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			low_q <= tic_pkg::RST_BYTE;
			high_q <= tic_pkg::RST_BYTE;
			ovf_q <= 1'b0;
			ovf_hi_q <= 1'b0;
		end else begin
			ovf_q <= 1'b0;
			ovf_hi_q <= 1'b0;
			if (wr_lo) begin
				low_q <= wdata;
			end
			if (wr_hi) begin
				high_q <= wdata;
			end
			if (!wr_lo && !wr_hi) begin
				unique case (mode)
				// RL5: 13-bit count
				tic_pkg::MODE_13BIT: if (inc_lo) begin
					if (low_q[4:0] == 5'h1F) begin
						low_q <= 8'h00;
						high_q <= high_q + 8'h01;
						ovf_q <= (high_q == 8'hFF);
					end else begin
						low_q <= {3'h0, low_q[4:0] + 5'h01};
					end
				end
				// RL5: full 16-bit count
				tic_pkg::MODE_16BIT: if (inc_lo) begin
					{high_q, low_q} <= {high_q, low_q} + 16'h0001;
					ovf_q <= ({high_q, low_q} == 16'hFFFF);
				end
				// RL6: 8-bit count with reload
				tic_pkg::MODE_RELOAD8: if (inc_lo) begin
					low_q <= (low_q == 8'hFF) ? high_q : low_q + 8'h01;
					ovf_q <= (low_q == 8'hFF);
				end
				// RL6: two independent 8-bit counters
				tic_pkg::MODE_SPLIT: begin
					if (inc_lo) begin
						low_q <= low_q + 8'h01;
						ovf_q <= (low_q == 8'hFF);
					end
					if (inc_hi) begin
						high_q <= high_q + 8'h01;
						ovf_hi_q <= (high_q == 8'hFF);
					end
				end
				endcase
			end
		end
	end
endmodule // tic_timer_unit
